/* File: test/dmx_xmem.sv */
`timescale 1ns/1ns
module dmx_xmem import dmx_pkg::*; (
   input wire logic mclk, // Clock
   input wire dmx_xbus_t xbus, // Bus from the core
   output logic [7:0] p0In // Port zero pin levels
);
   logic [7:0] mem [0:65535];
   logic [7:0] loAddr_ff;
   logic [7:0] lastPin_ff = 8'h00;
   logic [7:0] rdData;
   // low byte latched on ale, high byte from port two
   always @(posedge mclk) begin
      if (xbus.ale) loAddr_ff <= xbus.p0Out;
      if (!xbus.wrN) mem[{xbus.p2Out, loAddr_ff}] <= xbus.p0Out;
      lastPin_ff <= p0In;
   end
   assign rdData = mem[{xbus.p2Out, loAddr_ff}];
   // Released pins flip every cycle so a stale value is never read as data
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         if (xbus.p0Oe[k]) p0In[k] = xbus.p0Out[k];
         else if (!xbus.rdN) p0In[k] = rdData[k];
         else p0In[k] = ~lastPin_ff[k];
      end
   end
endmodule

/* File: test/test_data_move_mult_or_exec.sv */
`timescale 1ns/1ns
module test_data_move_mult_or_exec import dmx_pkg::*;;
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] msk;
      logic [15:0] ip;
      logic [7:0] p2;
   } dmx_note_t;
   typedef struct packed {
      logic we;
      logic [7:0] hi;
      logic [7:0] lo;
   } dmx_xnote_t;
   logic mclk, rst_n, ce, retire;
   logic [15:0] codeAddr, ipOut;
   logic [7:0] codeData, p0In, accOut, p2Latch;
   dmx_xbus_t xbus;
   logic [7:0] rom [0:511];
   logic [7:0] v [0:19];
   logic [7:0] a, p2e;
   logic [15:0] prod;
   dmx_note_t notes[$];
   dmx_xnote_t xnotes[$];
   int n_mismatch, n_compared, seed, pc;

   dmx_core u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .codeAddr(codeAddr),
      .codeData(codeData), .p0In(p0In), .xbus(xbus), .accOut(accOut), .ipOut(ipOut),
      .p2Latch(p2Latch), .retire(retire));
   dmx_xmem u_xmem (.mclk(mclk), .xbus(xbus), .p0In(p0In));
   assign codeData = rom[codeAddr[8:0]];

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Places one instruction and notes what the ports must show at its retire
   task automatic ins(input int n, input logic [7:0] b0, input logic [7:0] b1,
         input logic [7:0] b2, input logic [7:0] m);
      dmx_note_t t;
      rom[pc] = b0;
      if (n > 1) rom[pc + 1] = b1;
      if (n > 2) rom[pc + 2] = b2;
      pc = pc + n;
      t.acc = a;
      t.msk = m;
      t.ip = pc[15:0];
      t.p2 = p2e;
      notes.push_back(t);
   endtask

   task automatic ldA(input logic [7:0] d);
      a = d;
      ins(2, OP_A_IMM, d, 8'h00, BYTE_FF);
   endtask

   task automatic rdA(input logic [7:0] adr, input logic [7:0] e, input logic [7:0] m);
      a = e;
      ins(2, OP_A_DIR, adr, 8'h00, m);
   endtask

   task automatic xn(input logic we, input logic [7:0] hi, input logic [7:0] lo);
      dmx_xnote_t x;
      x.we = we;
      x.hi = hi;
      x.lo = lo;
      xnotes.push_back(x);
   endtask

   // Retire monitor: ip and port latch at the pulse, accumulator once it has landed
   initial begin : mon
      dmx_note_t t;
      logic [15:0] ipSeen;
      logic [7:0] p2Seen;
      forever begin
         @(negedge mclk);
         if (retire === 1'b1 && notes.size() > 0) begin
            ipSeen = ipOut;
            p2Seen = p2Latch;
            t = notes.pop_front();
            chk("ip", ipSeen, t.ip);
            chk("p2Latch", {8'h00, p2Seen}, {8'h00, t.p2});
            while (retire === 1'b1) @(negedge mclk);
            chk("acc", {8'h00, accOut & t.msk}, {8'h00, t.acc & t.msk});
         end
      end
   end

   initial begin : xmon
      dmx_xnote_t x;
      logic [7:0] lo;
      logic idlePrev;
      idlePrev = 1'b1;
      forever begin
         @(negedge mclk);
         if (xbus.ale === 1'b1) lo = xbus.p0Out;
         if ((xbus.rdN & xbus.wrN) === 1'b0 && idlePrev === 1'b1 && xnotes.size() > 0) begin
            x = xnotes.pop_front();
            chk("xwrite", {15'h0000, ~xbus.wrN}, {15'h0000, x.we});
            chk("xaddr", {xbus.p2Out, lo}, {x.hi, x.lo});
         end
         idlePrev = xbus.rdN & xbus.wrN;
      end
   end

   initial begin
      repeat (30000) @(posedge mclk);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      seed = 78501;
      pc = 0;
      a = RST_BYTE;
      p2e = RST_PORT;
      n_mismatch = 0;
      n_compared = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      for (int k = 0; k < 512; k++) rom[k] = OP_IDLE;
      for (int k = 0; k < 20; k++) v[k] = 8'($random(seed));
      ldA(v[0]);
      ins(2, 8'h7B, v[1], 8'h00, BYTE_FF);
      a = v[1];
      ins(1, 8'hEB, 8'h00, 8'h00, BYTE_FF);
      ins(2, OP_DIR_A, 8'h30, 8'h00, BYTE_FF);
      ins(3, OP_DIR_IMM, 8'h31, v[2], BYTE_FF);
      ins(3, OP_DIR_DIR, 8'h31, 8'h32, BYTE_FF);
      rdA(8'h32, v[2], BYTE_FF);
      ins(2, OP_A_DIR, ADR_ACC, 8'h00, BYTE_FF);
      ins(2, 8'h78, 8'h31, 8'h00, BYTE_FF);
      a = v[2];
      ins(1, 8'hE6, 8'h00, 8'h00, BYTE_FF);
      ins(2, 8'h79, 8'h40, 8'h00, BYTE_FF);
      ins(2, 8'h77, v[3], 8'h00, BYTE_FF);
      ins(2, 8'h87, 8'h33, 8'h00, BYTE_FF);
      rdA(8'h33, v[3], BYTE_FF);
      ins(2, 8'hAD, 8'h30, 8'h00, BYTE_FF);
      ins(2, 8'h8D, 8'h34, 8'h00, BYTE_FF);
      rdA(8'h34, v[1], BYTE_FF);
      ins(1, 8'hF7, 8'h00, 8'h00, BYTE_FF);
      ldA(8'h00);
      a = v[1];
      ins(1, 8'hE7, 8'h00, 8'h00, BYTE_FF);
      ins(2, 8'hA6, 8'h34, 8'h00, BYTE_FF);
      rdA(8'h31, v[1], BYTE_FF);
      // carry to and from a bit
      ins(3, OP_DIR_IMM, 8'h20, v[4], BYTE_FF);
      ins(2, OP_C_BIT, 8'h03, 8'h00, BYTE_FF);
      rdA(ADR_PSW, {v[4][3], 7'h00}, 8'h80);
      ins(3, OP_DIR_IMM, 8'h21, 8'h00, BYTE_FF);
      ins(2, OP_BIT_C, 8'h0F, 8'h00, BYTE_FF);
      rdA(8'h21, {v[4][3], 7'h00}, BYTE_FF);
      ins(3, OP_DP_LOAD, v[5], v[6], BYTE_FF);
      rdA(ADR_DPH, v[5], BYTE_FF);
      rdA(ADR_DPL, v[6], BYTE_FF);
      // pointer transfers keep the port latch
      p2e = v[8];
      ins(3, OP_DIR_IMM, ADR_PORT2, v[8], BYTE_FF);
      ldA(v[7]);
      ins(1, OP_XWR_DP, 8'h00, 8'h00, BYTE_FF);
      xn(1'b1, v[5], v[6]);
      ldA(8'h00);
      a = v[7];
      ins(1, OP_XRD_DP, 8'h00, 8'h00, BYTE_FF);
      xn(1'b0, v[5], v[6]);
      // indirect transfers, upper byte from the port latch
      ins(2, 8'h78, v[9], 8'h00, BYTE_FF);
      ldA(v[10]);
      ins(1, 8'hF2, 8'h00, 8'h00, BYTE_FF);
      xn(1'b1, v[8], v[9]);
      ldA(8'h00);
      a = v[10];
      ins(1, 8'hE2, 8'h00, 8'h00, BYTE_FF);
      xn(1'b0, v[8], v[9]);
      // carry out of the low byte reaches the high byte
      ins(3, OP_DP_LOAD, 8'h00, 8'hF8, BYTE_FF);
      ldA(8'h10);
      rom[9'h108] = v[12];
      a = v[12];
      ins(1, OP_TBL_DP, 8'h00, 8'h00, BYTE_FF);
      // table read relative to the advanced pointer
      ldA(8'hE0);
      rom[pc + 1 + 8'hE0] = v[13];
      a = v[13];
      ins(1, OP_TBL_IP, 8'h00, 8'h00, BYTE_FF);
      // product with carry set beforehand, range boundary both sides
      ins(3, OP_DIR_IMM, 8'h20, BYTE_FF, BYTE_FF);
      for (int k = 0; k < 3; k++) begin
         prod = (k == 0) ? 16'(v[14]) * 16'(v[15]) : ((k == 1) ? 16'h00FF : 16'h0100);
         ins(2, OP_C_BIT, 8'h03, 8'h00, BYTE_FF);
         ldA((k == 0) ? v[14] : ((k == 1) ? 8'h0F : 8'h10));
         ins(3, OP_DIR_IMM, ADR_SECOND, (k == 0) ? v[15] : ((k == 1) ? 8'h11 : 8'h10), BYTE_FF);
         a = prod[7:0];
         ins(1, OP_PRODUCT, 8'h00, 8'h00, BYTE_FF);
         rdA(ADR_SECOND, prod[15:8], BYTE_FF);
         rdA(ADR_PSW, (prod > 16'h00FF) ? 8'h04 : 8'h00, 8'h84);
      end
      ins(1, OP_IDLE, 8'h00, 8'h00, BYTE_FF);
      // byte OR, port operand from its latch
      ins(2, 8'h7A, v[16], 8'h00, BYTE_FF);
      ldA(v[17]);
      a = v[16] | v[17];
      ins(1, 8'h4A, 8'h00, 8'h00, BYTE_FF);
      p2e = v[8] | v[18];
      ins(3, OP_OR_DIR_IMM, ADR_PORT2, v[18], BYTE_FF);
      ins(3, OP_DIR_IMM, ADR_PSW, 8'h08, BYTE_FF);
      ins(2, 8'h7B, v[19], 8'h00, BYTE_FF);
      rdA(8'h0B, v[19], BYTE_FF);
      ins(3, OP_DIR_IMM, ADR_PSW, 8'h00, BYTE_FF);
      a = v[1];
      ins(1, 8'hEB, 8'h00, 8'h00, BYTE_FF);
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      // Clock enable drops on one clock in four at random, stretching whichever phase it hits
      for (int k = 0; k < 20000 && notes.size() > 0; k++) begin
         @(negedge mclk);
         ce = ($random(seed) & 3) != 0;
      end
      // Let the last accumulator check land before the verdict
      @(negedge mclk);
      ce = 1'b1;
      repeat (8) @(negedge mclk);
      if (notes.size() > 0 || xnotes.size() > 0) n_mismatch++;
      wrap_up();
   end
endmodule

/* File: verilog/dmx_core.sv */
`timescale 1ns/1ns
module dmx_core import dmx_pkg::*; (
   input wire logic mclk, // Clock, 100 MHz
   input wire logic rst_n, // Sync reset, active low
   input wire logic ce, // Clock enable
   output logic [15:0] codeAddr, // Program memory address
   input wire logic [7:0] codeData, // Program memory data, same clock
   input wire logic [7:0] p0In, // Port zero pins
   output dmx_xbus_t xbus, // External bus drive
   output logic [7:0] accOut, // Main working register
   output logic [15:0] ipOut, // Instruction pointer
   output logic [7:0] p2Latch, // Port two latch
   output logic retire // Retire pulse, one enabled clock long
);
   logic [7:0] iram [0:255];
   logic [7:0] acc_ff, b_ff, dph_ff, dpl_ff, p0l_ff, p2l_ff, psw_ff;
   logic [15:0] ip_ff;
   logic [7:0] op_ff, o1_ff, o2_ff;
   logic [1:0] got_ff, cnt_ff;
   logic [2:0] xcnt_ff;
   dmx_state_t st_ff;
   logic [7:0] p0Sync;
   logic [15:0] tblAddr;
   logic [15:0] product;

   dmx_sync #(.W(8)) uSync (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .din(p0In),
      .dout(p0Sync)
   );

   // RQ21 bank and index select
   logic [7:0] bankAdr, idxAdr, idxVal;
   assign bankAdr = {3'b000, psw_ff[4:3], op_ff[2:0]};
   assign idxAdr = {3'b000, psw_ff[4:3], 2'b00, op_ff[0]};
   assign idxVal = iram[idxAdr];

   // RQ20 port read uses latch when latch is set; port zero reads pins otherwise
   function automatic logic [7:0] rdDir(input logic [7:0] a, input logic latch);
      logic [7:0] r;
      r = RST_BYTE;
      if (a[7]) begin
         case (a)
            ADR_ACC: r = acc_ff;
            ADR_SECOND: r = b_ff;
            ADR_DPL: r = dpl_ff;
            ADR_DPH: r = dph_ff;
            ADR_PSW: r = psw_ff;
            ADR_PORT0: r = latch ? p0l_ff : p0Sync;
            ADR_PORT2: r = p2l_ff;
            default: r = RST_BYTE;
         endcase
      end else begin
         r = iram[a];
      end
      return r;
   endfunction

   // Decoded write: target address and value
   logic wrEn, accEn, carryEn, carryVal, bitEn, bEn, ovEn;
   logic [7:0] wrAdr, wrVal, accVal, bitByte;
   logic [1:0] nBytes, nCyc;
   always_comb begin
      logic [7:0] srcD;
      logic [7:0] bitRd;
      srcD = rdDir(o1_ff, 1'b0);
      bitRd = RST_BYTE;
      wrEn = 1'b0;
      wrAdr = RST_BYTE;
      wrVal = RST_BYTE;
      accEn = 1'b0;
      accVal = acc_ff;
      carryEn = 1'b0;
      carryVal = psw_ff[CARRY_POS];
      bitEn = 1'b0;
      bitByte = RST_BYTE;
      bEn = 1'b0;
      ovEn = 1'b0;
      nBytes = 2'd1;
      nCyc = 2'd1;
      // RQ2 accumulator copies
      if (op_ff[7:3] == PF_A_BANK) begin
         accEn = 1'b1;
         accVal = iram[bankAdr];
      end else if (op_ff[7:1] == PF_A_IND) begin
         accEn = 1'b1;
         accVal = iram[idxVal];
      end else if (op_ff == OP_A_IMM) begin
         nBytes = 2'd2;
         accEn = 1'b1;
         accVal = o1_ff;
      // RQ3 direct into accumulator
      end else if (op_ff == OP_A_DIR) begin
         nBytes = 2'd2;
         accEn = 1'b1;
         accVal = srcD;
      end else if (op_ff[7:3] == PF_BANK_A) begin
         wrEn = 1'b1;
         wrAdr = bankAdr;
         wrVal = acc_ff;
      // RQ4 bank register copies
      end else if (op_ff[7:3] == PF_BANK_DIR) begin
         nBytes = 2'd2;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = bankAdr;
         wrVal = srcD;
      end else if (op_ff[7:3] == PF_BANK_IMM) begin
         nBytes = 2'd2;
         wrEn = 1'b1;
         wrAdr = bankAdr;
         wrVal = o1_ff;
      // RQ5 direct destination copies
      end else if (op_ff == OP_DIR_A) begin
         nBytes = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = acc_ff;
      end else if (op_ff[7:3] == PF_DIR_BANK) begin
         nBytes = 2'd2;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = iram[bankAdr];
      end else if (op_ff == OP_DIR_IMM) begin
         nBytes = 2'd3;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = o2_ff;
      // RQ6 source byte first
      end else if (op_ff == OP_DIR_DIR) begin
         nBytes = 2'd3;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = o2_ff;
         wrVal = srcD;
      // RQ7 indirect destination copies
      end else if (op_ff[7:1] == PF_IND_A) begin
         wrEn = 1'b1;
         wrAdr = idxVal;
         wrVal = acc_ff;
      end else if (op_ff[7:1] == PF_IND_DIR) begin
         nBytes = 2'd2;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = idxVal;
         wrVal = srcD;
      end else if (op_ff[7:1] == PF_IND_IMM) begin
         nBytes = 2'd2;
         wrEn = 1'b1;
         wrAdr = idxVal;
         wrVal = o1_ff;
      // RQ8 indirect source to direct
      end else if (op_ff[7:1] == PF_DIR_IND) begin
         nBytes = 2'd2;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = iram[idxVal];
      // RQ9 carry with addressed bit
      end else if (op_ff == OP_C_BIT) begin
         nBytes = 2'd2;
         carryEn = 1'b1;
         bitByte = o1_ff[7] ? {o1_ff[7:3], 3'b000} : {4'h2, o1_ff[6:3]};
         bitRd = rdDir(bitByte, 1'b0);
         carryVal = bitRd[o1_ff[2:0]];
      end else if (op_ff == OP_BIT_C) begin
         nBytes = 2'd2;
         nCyc = 2'd2;
         bitEn = 1'b1;
         bitByte = o1_ff[7] ? {o1_ff[7:3], 3'b000} : {4'h2, o1_ff[6:3]};
         wrEn = 1'b1;
         wrAdr = bitByte;
         wrVal = rdDir(bitByte, 1'b1);
         wrVal[o1_ff[2:0]] = psw_ff[CARRY_POS];
      end else if (op_ff == OP_DP_LOAD) begin
         nBytes = 2'd3;
         nCyc = 2'd2;
      end else if (op_ff == OP_TBL_DP || op_ff == OP_TBL_IP) begin
         nCyc = 2'd2;
      end else if (op_ff[7:1] == PF_XRD_IND || op_ff[7:1] == PF_XWR_IND
                   || op_ff == OP_XRD_DP || op_ff == OP_XWR_DP) begin
         nCyc = 2'd2;
      // RQ17 product and flags
      end else if (op_ff == OP_PRODUCT) begin
         nCyc = 2'd3;
         accEn = 1'b1;
         accVal = product[7:0];
         bEn = 1'b1;
         ovEn = 1'b1;
      // RQ19 byte OR forms
      end else if (op_ff[7:3] == PF_OR_BANK) begin
         accEn = 1'b1;
         accVal = acc_ff | iram[bankAdr];
      end else if (op_ff[7:1] == PF_OR_IND) begin
         accEn = 1'b1;
         accVal = acc_ff | iram[idxVal];
      end else if (op_ff == OP_OR_A_DIR) begin
         nBytes = 2'd2;
         accEn = 1'b1;
         accVal = acc_ff | srcD;
      end else if (op_ff == OP_OR_A_IMM) begin
         nBytes = 2'd2;
         accEn = 1'b1;
         accVal = acc_ff | o1_ff;
      end else if (op_ff == OP_OR_DIR_A) begin
         nBytes = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = rdDir(o1_ff, 1'b1) | acc_ff;
      end else if (op_ff == OP_OR_DIR_IMM) begin
         nBytes = 2'd3;
         nCyc = 2'd2;
         wrEn = 1'b1;
         wrAdr = o1_ff;
         wrVal = rdDir(o1_ff, 1'b1) | o2_ff;
      end
   end

   assign product = 16'(acc_ff) * 16'(b_ff);
   // RQ11 RQ12 sixteen-bit table address
   assign tblAddr = ((op_ff == OP_TBL_IP) ? ip_ff : {dph_ff, dpl_ff}) + 16'(acc_ff);
   logic isExt, extDp, extWr;
   assign isExt = (op_ff[7:1] == PF_XRD_IND) || (op_ff[7:1] == PF_XWR_IND)
                  || (op_ff == OP_XRD_DP) || (op_ff == OP_XWR_DP);
   assign extDp = ~op_ff[1];
   assign extWr = op_ff[4];
   assign codeAddr = (st_ff == ST_WAIT && (op_ff == OP_TBL_DP || op_ff == OP_TBL_IP))
                     ? tblAddr : ip_ff;

   // RQ22 fetch, operand and cycle sequencing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff <= ST_FETCH;
         ip_ff <= RST_IP;
         op_ff <= RST_BYTE;
         o1_ff <= RST_BYTE;
         o2_ff <= RST_BYTE;
         got_ff <= 2'd0;
         cnt_ff <= 2'd0;
         xcnt_ff <= 3'h0;
         retire <= 1'b0;
      end else if (ce) begin
         retire <= 1'b0;
         case (st_ff)
            ST_FETCH: begin
               op_ff <= codeData;
               ip_ff <= ip_ff + 16'h0001;
               got_ff <= 2'd1;
               cnt_ff <= 2'd1;
               st_ff <= ST_OPS;
            end
            ST_OPS: begin
               if (got_ff < nBytes) begin
                  if (got_ff == 2'd1) o1_ff <= codeData;
                  else o2_ff <= codeData;
                  ip_ff <= ip_ff + 16'h0001;
                  got_ff <= got_ff + 2'd1;
               end else begin
                  st_ff <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               st_ff <= (cnt_ff >= nCyc) ? ST_FETCH : (isExt ? ST_EXT : ST_WAIT);
               retire <= (cnt_ff >= nCyc);
               cnt_ff <= cnt_ff + 2'd1;
               xcnt_ff <= 3'h0;
            end
            ST_WAIT: begin
               cnt_ff <= cnt_ff + 2'd1;
               if (cnt_ff >= nCyc) begin
                  st_ff <= ST_FETCH;
                  retire <= 1'b1;
               end
            end
            // Bus phase runs on its own count so the pin filter can settle
            ST_EXT: begin
               xcnt_ff <= xcnt_ff + 3'h1;
               if (xcnt_ff == XF_LAST) begin
                  st_ff <= ST_FETCH;
                  retire <= 1'b1;
               end
            end
            default: st_ff <= ST_FETCH;
         endcase
      end
   end

   // RQ1 single destination write
   logic doWr;
   assign doWr = (st_ff == ST_EXEC) && wrEn;
   always_ff @(posedge mclk) begin
      if (ce && doWr && !wrAdr[7]) iram[wrAdr] <= wrVal;
   end

   // RQ18 idle touches nothing but pointer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         acc_ff <= RST_BYTE;
         b_ff <= RST_BYTE;
         dph_ff <= RST_BYTE;
         dpl_ff <= RST_BYTE;
         psw_ff <= RST_BYTE;
         p0l_ff <= RST_PORT;
         p2l_ff <= RST_PORT;
      end else if (ce) begin
         if (st_ff == ST_EXEC && op_ff != OP_IDLE) begin
            if (doWr && wrAdr[7]) begin
               case (wrAdr)
                  ADR_ACC: acc_ff <= wrVal;
                  ADR_SECOND: b_ff <= wrVal;
                  ADR_DPL: dpl_ff <= wrVal;
                  ADR_DPH: dph_ff <= wrVal;
                  ADR_PSW: psw_ff <= wrVal;
                  ADR_PORT0: p0l_ff <= wrVal;
                  ADR_PORT2: p2l_ff <= wrVal;
                  default: ;
               endcase
            end
            if (accEn) acc_ff <= accVal;
            if (bEn) b_ff <= product[15:8];
            if (ovEn) begin
               psw_ff[RANGE_POS] <= (product > 16'(BYTE_FF));
               psw_ff[CARRY_POS] <= 1'b0;
            end
            if (carryEn) psw_ff[CARRY_POS] <= carryVal;
            // RQ10 high byte from second byte
            if (op_ff == OP_DP_LOAD) begin
               dph_ff <= o1_ff;
               dpl_ff <= o2_ff;
            end
         end
         // RQ11 table byte into accumulator
         if (st_ff == ST_WAIT && (op_ff == OP_TBL_DP || op_ff == OP_TBL_IP)) begin
            acc_ff <= codeData;
         end
         if (st_ff == ST_EXT && !extWr && xcnt_ff == XF_LAST) acc_ff <= p0Sync;
      end
   end

   // RQ13 RQ14 external bus phases
   // RQ15 port two latch kept; only pins show high byte
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xbus <= '{p0Out: RST_PORT, p0Oe: RST_BYTE, p2Out: RST_PORT,
                   ale: 1'b0, rdN: 1'b1, wrN: 1'b1};
      end else if (ce) begin
         xbus.ale <= 1'b0;
         xbus.rdN <= 1'b1;
         xbus.wrN <= 1'b1;
         xbus.p0Oe <= RST_BYTE;
         xbus.p0Out <= p0l_ff;
         xbus.p2Out <= p2l_ff;
         if (isExt && st_ff == ST_EXEC) begin
            xbus.ale <= 1'b1;
            xbus.p0Oe <= BYTE_FF;
            xbus.p0Out <= extDp ? dpl_ff : idxVal;
            if (extDp) xbus.p2Out <= dph_ff;
         end else if (isExt && st_ff == ST_EXT) begin
            if (extDp) xbus.p2Out <= dph_ff;
            // Strobe stretched: read data must stand through the three-flop filter
            if (xcnt_ff < XF_STROBE) begin
               xbus.rdN <= extWr;
               xbus.wrN <= ~extWr;
               xbus.p0Oe <= extWr ? BYTE_FF : RST_BYTE;
               xbus.p0Out <= acc_ff;
            end
         end
      end
   end

   assign accOut = acc_ff;
   assign ipOut = ip_ff;
   assign p2Latch = p2l_ff;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_prod;
      st_ff == ST_EXEC && op_ff == OP_PRODUCT && ce |=> acc_ff == $past(product[7:0]);
   endproperty
   a_prod: assert property (p_prod) else $error("product low byte wrong"); // RQ17
   property p_idle;
      st_ff == ST_EXEC && op_ff == OP_IDLE && ce |=> $stable(acc_ff) && $stable(psw_ff);
   endproperty
   a_idle: assert property (p_idle) else $error("idle op changed state"); // RQ18
   property p_dpl;
      st_ff == ST_EXEC && op_ff == OP_DP_LOAD && ce |=> dph_ff == $past(o1_ff);
   endproperty
   a_dpl: assert property (p_dpl) else $error("pointer high byte wrong"); // RQ10
   property p_p2;
      st_ff == ST_EXT && extDp |-> $stable(p2l_ff);
   endproperty
   a_p2: assert property (p_p2) else $error("port two latch moved"); // RQ15
   property p_ext;
      st_ff == ST_EXEC && isExt && ce |=> xbus.ale && xbus.p0Oe == BYTE_FF;
   endproperty
   a_ext: assert property (p_ext) else $error("no address phase"); // RQ13
   property p_xhi;
      st_ff == ST_EXT && extDp && !(xbus.rdN && xbus.wrN) |-> xbus.p2Out == dph_ff;
   endproperty
   a_xhi: assert property (p_xhi) else $error("high address byte missing"); // RQ14
   property p_ip;
      retire |-> st_ff == ST_FETCH;
   endproperty
   a_ip: assert property (p_ip) else $error("retire outside fetch"); // RQ22
   property p_carry;
      st_ff == ST_EXEC && op_ff == OP_PRODUCT && ce |=> !psw_ff[CARRY_POS];
   endproperty
   a_carry: assert property (p_carry) else $error("carry not cleared"); // RQ17
   property p_imm;
      st_ff == ST_EXEC && op_ff == OP_A_IMM && ce |=> acc_ff == $past(o1_ff);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate copy wrong"); // RQ2
   c_prod: cover property (st_ff == ST_EXEC && op_ff == OP_PRODUCT);
   c_ext: cover property (st_ff == ST_EXT);
   c_tbl: cover property (st_ff == ST_WAIT && op_ff == OP_TBL_IP);
endmodule

/* File: verilog/dmx_pkg.sv */
// Operation
// RQ1: Byte copy writes destination only, no flags
// RQ2: Accumulator copies from bank, indirect, immediate
// RQ3: Direct load into accumulator; self-address undefined
// RQ4: Bank register copies from direct, immediate
// RQ5: Direct destination from accumulator, bank, immediate
// RQ6: Direct-to-direct: source address byte first
// RQ7: Indirect destination from accumulator, direct, immediate
// RQ8: Indirect source into direct address, two cycles
// RQ9: Bit copies always pair carry with bit
// RQ10: Pointer load: high byte then low byte
// RQ11: Table read at accumulator plus base, sixteen-bit
// RQ12: Instruction-pointer table read uses advanced pointer
// RQ13: Indirect external transfer: 8-bit address on port_zero
// RQ14: Pointer external transfer: high on port_two
// RQ15: Port two latch unchanged during transfer
// RQ16: Software drives upper address before transfer
// RQ17: Product: low to accumulator, high to second
// RQ18: Idle op only advances instruction pointer
// RQ19: Byte OR stores result, flags untouched
// RQ20: OR on port reads output latch
// RQ21: Field rrr selects bank register, i index
// RQ22: Retire after cycles; pointer advances by bytes
package dmx_pkg;
   localparam logic [7:0] OP_IDLE = 8'h00;
   localparam logic [7:0] OP_A_DIR = 8'hE5;
   localparam logic [7:0] OP_A_IMM = 8'h74;
   localparam logic [7:0] OP_DIR_A = 8'hF5;
   localparam logic [7:0] OP_DIR_DIR = 8'h85;
   localparam logic [7:0] OP_DIR_IMM = 8'h75;
   localparam logic [7:0] OP_C_BIT = 8'hA2;
   localparam logic [7:0] OP_BIT_C = 8'h92;
   localparam logic [7:0] OP_DP_LOAD = 8'h90;
   localparam logic [7:0] OP_TBL_DP = 8'h93;
   localparam logic [7:0] OP_TBL_IP = 8'h83;
   localparam logic [7:0] OP_XRD_DP = 8'hE0;
   localparam logic [7:0] OP_XWR_DP = 8'hF0;
   localparam logic [7:0] OP_PRODUCT = 8'hA4;
   localparam logic [7:0] OP_OR_A_DIR = 8'h45;
   localparam logic [7:0] OP_OR_A_IMM = 8'h44;
   localparam logic [7:0] OP_OR_DIR_A = 8'h42;
   localparam logic [7:0] OP_OR_DIR_IMM = 8'h43;
   // Five-bit prefixes (rrr forms) and seven-bit prefixes (i forms)
   localparam logic [4:0] PF_A_BANK = 5'h1D;
   localparam logic [4:0] PF_BANK_A = 5'h1F;
   localparam logic [4:0] PF_BANK_DIR = 5'h15;
   localparam logic [4:0] PF_BANK_IMM = 5'h0F;
   localparam logic [4:0] PF_DIR_BANK = 5'h11;
   localparam logic [4:0] PF_OR_BANK = 5'h09;
   localparam logic [6:0] PF_A_IND = 7'h73;
   localparam logic [6:0] PF_IND_A = 7'h7B;
   localparam logic [6:0] PF_IND_DIR = 7'h53;
   localparam logic [6:0] PF_IND_IMM = 7'h3B;
   localparam logic [6:0] PF_DIR_IND = 7'h43;
   localparam logic [6:0] PF_XRD_IND = 7'h71;
   localparam logic [6:0] PF_XWR_IND = 7'h79;
   localparam logic [6:0] PF_OR_IND = 7'h23;
   // Special register direct addresses
   localparam logic [7:0] ADR_PORT0 = 8'h80;
   localparam logic [7:0] ADR_PORT2 = 8'hA0;
   localparam logic [7:0] ADR_DPL = 8'h82;
   localparam logic [7:0] ADR_DPH = 8'h83;
   localparam logic [7:0] ADR_PSW = 8'hD0;
   localparam logic [7:0] ADR_ACC = 8'hE0;
   localparam logic [7:0] ADR_SECOND = 8'hF0;
   localparam logic [7:0] BIT_CARRY = 8'hD7;
   localparam logic [7:0] BYTE_FF = 8'hFF;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_PORT = 8'hFF;
   localparam logic [15:0] RST_IP = 16'h0000;
   localparam int CARRY_POS = 7;
   localparam int RANGE_POS = 2;
   localparam int BANK_LO = 3;
   // External strobe length and data capture point, in enabled clocks
   localparam logic [2:0] XF_STROBE = 3'h4;
   localparam logic [2:0] XF_LAST = 3'h5;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b000,
      ST_OPS = 3'b001,
      ST_EXEC = 3'b010,
      ST_WAIT = 3'b011,
      ST_EXT = 3'b100
   } dmx_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
   } dmx_mem_t;

   typedef struct packed {
      logic [7:0] p0Out;
      logic [7:0] p0Oe;
      logic [7:0] p2Out;
      logic ale;
      logic rdN;
      logic wrN;
   } dmx_xbus_t;
endpackage

/* File: verilog/dmx_sync.sv */
`timescale 1ns/1ns
module dmx_sync import dmx_pkg::*; #(
   parameter int W = 8
) (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Sync reset
   input wire logic ce, // Clock enable
   input wire logic [W-1:0] din, // Async input
   output logic [W-1:0] dout // Filtered level
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff;
   // Change accepted only when the two later stages agree
   genvar g;
   for (g = 0; g < W; g++) begin : gBit
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            s1_ff[g] <= 1'b0;
            s2_ff[g] <= 1'b0;
            s3_ff[g] <= 1'b0;
            dout[g] <= 1'b0;
         end else if (ce) begin
            s1_ff[g] <= din[g];
            s2_ff[g] <= s1_ff[g];
            s3_ff[g] <= s2_ff[g];
            if (s2_ff[g] == s3_ff[g]) begin
               dout[g] <= s3_ff[g];
            end
         end
      end
   end
endmodule
